// File: mbi_pkg.sv
// Shared constants and types for the branch and miscellaneous instruction unit
package mbi_pkg;
    // APB byte addresses
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_OPND = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_ACC = 8'h0c;
    localparam logic [7:0] ADDR_PC = 8'h10;
    localparam logic [7:0] ADDR_TABLE_HIGH = 8'h14;
    localparam logic [7:0] ADDR_STACK = 8'h18;
    localparam logic [7:0] ADDR_WAKE = 8'h1c;
    localparam logic [1:0] MEM_WIN_TAG = 2'h1;
    // Instruction register fields
    localparam int INSTR_OP_LSB = 0;
    localparam int INSTR_M_LSB = 8;
    localparam int INSTR_BIT_LSB = 12;
    // Status register fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_HALT_BIT = 1;
    localparam int ST_TIMEOUT_BIT = 2;
    localparam int ST_POWERDOWN_BIT = 3;
    localparam int ST_SKIP_BIT = 4;
    localparam int ST_PRE1_BIT = 5;
    localparam int ST_PRE2_BIT = 6;
    localparam int ST_CYC_LSB = 8;
    // Core geometry and reset values
    localparam int PC_W = 13;
    localparam int MEM_DEPTH = 16;
    localparam logic [3:0] PC_LOW_INDEX = 4'h2;
    localparam logic [4:0] LAST_PAGE = 5'h1f;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    // Timing: one instruction cycle is four system clocks
    localparam int CLKS_PER_ICYCLE = 4;
    localparam logic [2:0] ICYCLE_LAST = 3'(CLKS_PER_ICYCLE - 1);

    typedef enum logic [4:0] {
        MBI_NOP_OP = 5'h00,
        MBI_JUMP_OP = 5'h01,
        MBI_SKIP_ZERO_OP = 5'h02,
        MBI_SKIP_ZERO_COPY_OP = 5'h03,
        MBI_SKIP_BIT_CLEAR_OP = 5'h04,
        MBI_SKIP_BIT_SET_OP = 5'h05,
        MBI_INC_SKIP_ZERO_OP = 5'h06,
        MBI_DEC_SKIP_ZERO_OP = 5'h07,
        MBI_INC_SKIP_ZERO_ACC_OP = 5'h08,
        MBI_DEC_SKIP_ZERO_ACC_OP = 5'h09,
        MBI_RETURN_OP = 5'h0a,
        MBI_RETURN_IMM_OP = 5'h0b,
        MBI_RETURN_FROM_IRQ_OP = 5'h0c,
        MBI_TABLE_READ_CURRENT_PAGE = 5'h0d,
        MBI_TABLE_READ_LAST_PAGE = 5'h0e,
        MBI_CLEAR_MEM_OP = 5'h0f,
        MBI_SET_MEM_OP = 5'h10,
        MBI_WATCHDOG_CLEAR = 5'h11,
        MBI_WATCHDOG_PRECLEAR_ONE = 5'h12,
        MBI_WATCHDOG_PRECLEAR_TWO = 5'h13,
        MBI_NIBBLE_EXCHANGE = 5'h14,
        MBI_NIBBLE_EXCHANGE_TO_ACC = 5'h15,
        MBI_HALT_OP = 5'h16
    } mbi_op_type;

    typedef enum logic [3:0] {
        MBI_ST_IDLE = 4'b0001,
        MBI_ST_EXEC = 4'b0010,
        MBI_ST_EXTRA = 4'b0100,
        MBI_ST_HALT = 4'b1000
    } mbi_state_type;
endpackage

// File: mbi_cycle_timer.sv
// Instruction cycle divider: one-cycle tick every four system clocks
module mbi_cycle_timer
    import mbi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    output logic tick
);
    logic [2:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 3'h0;
        end else if (restart || cnt_reg == ICYCLE_LAST) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    assign tick = !restart && cnt_reg == ICYCLE_LAST;
endmodule

// File: mbi_exec_unit.sv
// Branch, skip, return, table read and miscellaneous instruction unit
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module mbi_exec_unit
    import mbi_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic wdt_timeout,
    output logic wdt_clear,
    output logic powerdown
);
    mbi_state_type state_reg;
    mbi_op_type op_reg;
    logic [3:0] m_reg;
    logic [2:0] bit_reg;
    logic [PC_W-1:0] opnd_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] stack_reg;
    logic [7:0] acc_reg;
    logic [7:0] table_high_reg;
    logic [7:0] mem_reg [MEM_DEPTH];
    logic timeout_flag_reg;
    logic powerdown_flag_reg;
    logic pre1_reg;
    logic pre2_reg;
    logic skip_reg;
    logic [1:0] extra_reg;
    logic [2:0] cycles_reg;
    logic wdt_clear_reg;
    logic [31:0] prdata_reg;

    // Bus decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    wire mem_hit = paddr[7:6] == MEM_WIN_TAG && paddr[1:0] == 2'h0;
    wire reg_hit = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
    wire [3:0] mem_idx = paddr[5:2];
    wire idle = state_reg == MBI_ST_IDLE;
    wire launch = wr_en && paddr == ADDR_INSTR && idle;
    wire wr_idle = wr_en && idle;
    wire tick;
    wire exec_end = state_reg == MBI_ST_EXEC && tick;

    mbi_cycle_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(launch),
        .tick(tick)
    );

    // Operand fetch; the low byte of the counter aliases one memory slot
    wire to_pc_low = m_reg == PC_LOW_INDEX;
    wire [7:0] mem_val = to_pc_low ? pc_reg[7:0] : mem_reg[m_reg];
    wire [7:0] inc_val = mem_val + 8'h01;
    wire [7:0] dec_val = mem_val - 8'h01;
    wire [7:0] swap_val = {mem_val[3:0], mem_val[7:4]};
    wire test_bit = mem_val[bit_reg];
    wire pair_done = (op_reg == MBI_WATCHDOG_PRECLEAR_ONE && pre2_reg)
        || (op_reg == MBI_WATCHDOG_PRECLEAR_TWO && pre1_reg);

    logic do_mem;
    logic [7:0] mem_new;
    logic do_acc;
    logic [7:0] acc_new;
    logic skip;
    logic long_op;
    logic [1:0] pc_src;

    always_comb begin
        do_mem = 1'b0;
        mem_new = 8'h00;
        do_acc = 1'b0;
        acc_new = 8'h00;
        skip = 1'b0;
        long_op = 1'b0;
        pc_src = 2'd0;
        case (op_reg)
            MBI_JUMP_OP: begin
                long_op = 1'b1;
                pc_src = 2'd1;
            end
            MBI_SKIP_ZERO_OP: skip = mem_val == 8'h00;
            MBI_SKIP_ZERO_COPY_OP: begin
                skip = mem_val == 8'h00;
                do_acc = 1'b1;
                acc_new = mem_val;
            end
            MBI_SKIP_BIT_CLEAR_OP: skip = !test_bit;
            MBI_SKIP_BIT_SET_OP: skip = test_bit;
            MBI_INC_SKIP_ZERO_OP: begin
                do_mem = 1'b1;
                mem_new = inc_val;
                skip = inc_val == 8'h00;
            end
            MBI_DEC_SKIP_ZERO_OP: begin
                do_mem = 1'b1;
                mem_new = dec_val;
                skip = dec_val == 8'h00;
            end
            MBI_INC_SKIP_ZERO_ACC_OP: begin
                do_acc = 1'b1;
                acc_new = inc_val;
                skip = inc_val == 8'h00;
            end
            MBI_DEC_SKIP_ZERO_ACC_OP: begin
                do_acc = 1'b1;
                acc_new = dec_val;
                skip = dec_val == 8'h00;
            end
            MBI_RETURN_OP, MBI_RETURN_FROM_IRQ_OP: begin
                long_op = 1'b1;
                pc_src = 2'd2;
            end
            MBI_RETURN_IMM_OP: begin
                long_op = 1'b1;
                pc_src = 2'd2;
                do_acc = 1'b1;
                acc_new = opnd_reg[7:0];
            end
            MBI_TABLE_READ_CURRENT_PAGE, MBI_TABLE_READ_LAST_PAGE: begin
                long_op = 1'b1;
                do_mem = 1'b1;
                mem_new = prog_data[7:0];
            end
            MBI_CLEAR_MEM_OP: begin
                do_mem = 1'b1;
                mem_new = 8'h00;
            end
            MBI_SET_MEM_OP: begin
                do_mem = 1'b1;
                mem_new = 8'hff;
            end
            MBI_NIBBLE_EXCHANGE: begin
                do_mem = 1'b1;
                mem_new = swap_val;
            end
            MBI_NIBBLE_EXCHANGE_TO_ACC: begin
                do_acc = 1'b1;
                acc_new = swap_val;
            end
            default: pc_src = 2'd0;
        endcase
    end

    // Penalty cycles over a one-cycle base: two-cycle instructions, taken skip, write to counter low byte
    wire pc_low_write = do_mem && to_pc_low;
    wire [1:0] extra = 2'(long_op) + 2'(skip) + 2'(pc_low_write);
    wire [PC_W-1:0] pc_seq = pc_reg + (skip ? 13'h0002 : 13'h0001);
    wire [PC_W-1:0] pc_after = pc_low_write ? {pc_reg[PC_W-1:8], mem_new}
        : (pc_src == 2'd1) ? opnd_reg : (pc_src == 2'd2) ? stack_reg : pc_seq;
    wire is_halt = op_reg == MBI_HALT_OP;
    wire wdt_hit = op_reg == MBI_WATCHDOG_CLEAR || pair_done;

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MBI_ST_IDLE;
            extra_reg <= 2'd0;
        end else begin
            case (state_reg)
                MBI_ST_IDLE: if (launch) state_reg <= MBI_ST_EXEC;
                MBI_ST_EXEC: if (tick) begin
                    extra_reg <= extra;
                    if (is_halt) state_reg <= MBI_ST_HALT;
                    else if (extra != 2'd0) state_reg <= MBI_ST_EXTRA;
                    else state_reg <= MBI_ST_IDLE;
                end
                MBI_ST_EXTRA: if (tick) begin
                    extra_reg <= extra_reg - 2'd1;
                    if (extra_reg == 2'd1) state_reg <= MBI_ST_IDLE;
                end
                MBI_ST_HALT: if (wr_en && paddr == ADDR_WAKE && pwdata[0]) begin
                    state_reg <= MBI_ST_IDLE;
                end
                default: state_reg <= MBI_ST_IDLE;
            endcase
        end
    end

    // Instruction latch and program memory address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_reg <= MBI_NOP_OP;
            m_reg <= 4'h0;
            bit_reg <= 3'h0;
            prog_addr <= PC_RESET;
        end else if (launch) begin
            op_reg <= mbi_op_type'(pwdata[INSTR_OP_LSB +: 5]);
            m_reg <= pwdata[INSTR_M_LSB +: 4];
            bit_reg <= pwdata[INSTR_BIT_LSB +: 3];
            prog_addr <= pwdata[4:0] == MBI_TABLE_READ_LAST_PAGE
                ? {LAST_PAGE, opnd_reg[7:0]} : {pc_reg[PC_W-1:8], opnd_reg[7:0]};
        end
    end

    // Architectural state; software may load it only while idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg <= PC_RESET;
            acc_reg <= ACC_RESET;
            opnd_reg <= PC_RESET;
            stack_reg <= PC_RESET;
            table_high_reg <= 8'h00;
            skip_reg <= 1'b0;
            cycles_reg <= 3'd0;
        end else if (exec_end) begin
            pc_reg <= pc_after;
            skip_reg <= skip;
            cycles_reg <= 3'd1 + 3'(extra);
            if (do_acc) acc_reg <= acc_new;
            if (op_reg == MBI_TABLE_READ_CURRENT_PAGE || op_reg == MBI_TABLE_READ_LAST_PAGE) begin
                table_high_reg <= prog_data[15:8];
            end
        end else if (wr_idle) begin
            if (paddr == ADDR_PC) pc_reg <= pwdata[PC_W-1:0];
            if (paddr == ADDR_ACC) acc_reg <= pwdata[7:0];
            if (paddr == ADDR_OPND) opnd_reg <= pwdata[PC_W-1:0];
            if (paddr == ADDR_STACK) stack_reg <= pwdata[PC_W-1:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (exec_end && do_mem && !to_pc_low) begin
            mem_reg[m_reg] <= mem_new;
        end else if (wr_idle && mem_hit) begin
            mem_reg[mem_idx] <= pwdata[7:0];
        end
    end

    // Watchdog flags; a time-out in the same cycle wins over a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_reg <= 1'b0;
            powerdown_flag_reg <= 1'b0;
            pre1_reg <= 1'b0;
            pre2_reg <= 1'b0;
            wdt_clear_reg <= 1'b0;
        end else begin
            wdt_clear_reg <= exec_end && (wdt_hit || is_halt);
            if (exec_end && (wdt_hit || is_halt)) timeout_flag_reg <= 1'b0;
            if (wdt_timeout) timeout_flag_reg <= 1'b1;
            if (exec_end && wdt_hit) begin
                powerdown_flag_reg <= 1'b0;
                pre1_reg <= 1'b0;
                pre2_reg <= 1'b0;
            end else if (exec_end && is_halt) begin
                powerdown_flag_reg <= 1'b1;
            end else if (exec_end && op_reg == MBI_WATCHDOG_PRECLEAR_ONE) begin
                pre1_reg <= 1'b1;
            end else if (exec_end && op_reg == MBI_WATCHDOG_PRECLEAR_TWO) begin
                pre2_reg <= 1'b1;
            end
        end
    end

    // Read data is captured in the setup phase and shown in the access phase
    wire [31:0] status_word = {21'h0, cycles_reg, 1'b0, pre2_reg, pre1_reg, skip_reg,
        powerdown_flag_reg, timeout_flag_reg, state_reg == MBI_ST_HALT, !idle};
    wire [31:0] rd_word =
        mem_hit ? {24'h0, mem_idx == PC_LOW_INDEX ? pc_reg[7:0] : mem_reg[mem_idx]}
        : paddr == ADDR_INSTR ? {17'h0, bit_reg, m_reg, 3'h0, op_reg}
        : paddr == ADDR_OPND ? {19'h0, opnd_reg}
        : paddr == ADDR_STATUS ? status_word
        : paddr == ADDR_ACC ? {24'h0, acc_reg}
        : paddr == ADDR_PC ? {19'h0, pc_reg}
        : paddr == ADDR_TABLE_HIGH ? {24'h0, table_high_reg}
        : paddr == ADDR_STACK ? {19'h0, stack_reg} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_reg <= 32'h0;
        else if (setup && !pwrite) prdata_reg <= rd_word;
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(mem_hit || reg_hit);
    assign wdt_clear = wdt_clear_reg;
    assign powerdown = state_reg == MBI_ST_HALT;

    // Checks
    logic [4:0] busy_clks;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy_clks <= 5'd0;
        else if (launch) busy_clks <= 5'd0;
        else if (!idle && state_reg != MBI_ST_HALT) busy_clks <= busy_clks + 5'd1;
    end

    sequence ends_with(mbi_op_type op);
        exec_end && op_reg == op;
    endsequence

    jump_two_cycles_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_JUMP_OP) |=> state_reg == MBI_ST_EXTRA [*4] ##1 idle && pc_reg == opnd_reg)
        else $error("jump timing or target wrong");
    skip_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_SKIP_ZERO_COPY_OP) |=> skip_reg == ($past(mem_val) == 8'h00)
        && acc_reg == $past(mem_val)) else $error("skip zero copy wrong");
    bit_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_SKIP_BIT_SET_OP) && test_bit |=> pc_reg == $past(pc_reg) + 13'h0002)
        else $error("bit skip did not advance by two");
    inc_writeback_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_INC_SKIP_ZERO_OP) && !to_pc_low |=> mem_reg[m_reg] == $past(inc_val))
        else $error("increment not written back");
    acc_variant_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_DEC_SKIP_ZERO_ACC_OP) |=> acc_reg == $past(dec_val)
        && skip_reg == ($past(dec_val) == 8'h00)) else $error("acc decrement wrong");
    ret_imm_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_RETURN_IMM_OP) |=> acc_reg == $past(opnd_reg[7:0])
        && pc_reg == $past(stack_reg) && cycles_reg == 3'd2) else $error("return imm wrong");
    table_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_TABLE_READ_CURRENT_PAGE) |=> table_high_reg == $past(prog_data[15:8]))
        else $error("table high latch wrong");
    preclear_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_WATCHDOG_PRECLEAR_ONE) && !pre2_reg |=> pre1_reg
        && $stable(powerdown_flag_reg) && !wdt_clear) else $error("single preclear acted");
    wdt_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_WATCHDOG_CLEAR) && !wdt_timeout |=> !timeout_flag_reg
        && !powerdown_flag_reg && wdt_clear) else $error("watchdog clear failed");
    halt_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        ends_with(MBI_HALT_OP) && !wdt_timeout |=> powerdown && powerdown_flag_reg
        && !timeout_flag_reg && wdt_clear) else $error("halt entry wrong");
    cycle_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(idle) && $past(state_reg) != MBI_ST_HALT |->
        busy_clks == 5'(cycles_reg) * 5'(CLKS_PER_ICYCLE)) else $error("cycle count wrong");
    dummy_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == MBI_ST_EXTRA |=> $stable(acc_reg) && $stable(table_high_reg))
        else $error("dummy cycle changed state");
endmodule

// File: tb_mbi_exec_unit.sv
// Self-checking bench for the branch and miscellaneous instruction unit
module tb_mbi_exec_unit import mbi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic e;} mbi_note_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic wdt_timeout, wdt_clear, powerdown;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [PC_W-1:0] prog_addr;
    logic [15:0] prog_data;
    int err_count, total_checks, cyc_n, wclr_n;
    integer seed;
    logic to_m, pwrdn_m, p1_m, p2_m;
    mbi_note_type notes[$];
    mbi_note_type cur;

    mbi_exec_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data),
        .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear), .powerdown(powerdown));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [15:0] rom(input logic [12:0] a);
        return {~a[7:0], a[12:5]};
    endfunction
    function automatic logic [7:0] ma(input int m);
        return 8'(8'h40 + 4 * m);
    endfunction

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check_read(input mbi_note_type n, input logic [31:0] got, input logic e);
        total_checks++;
        if ((got & n.m) !== (n.d & n.m) || e !== n.e) begin
            err_count++;
            $display("unexpected read %h exp %h/%b got %h/%b", n.a, n.d & n.m, n.e, got, e);
        end
    endtask
    task automatic check_port(input string s, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1,
                      input logic e = 1'b0);
        logic [31:0] q;
        notes.push_back('{a, d, m, e});
        apb(1'b0, a, 32'h0, q);
    endtask
    task automatic run(input mbi_op_type op, input int m, input int b, input logic [31:0] opnd,
                       input int cyc, input logic sk);
        logic [31:0] q;
        wr(ADDR_OPND, opnd);
        wr(ADDR_INSTR, {17'h0, 3'(b), 4'(m), 3'h0, op});
        do begin
            notes.push_back('{ADDR_STATUS, 32'h0, 32'h0, 1'b0});
            apb(1'b0, ADDR_STATUS, 32'h0, q);
        end while (q[ST_BUSY_BIT] !== 1'b0 && q[ST_HALT_BIT] !== 1'b1);
        // Busy stays high while halted
        rd(ADDR_STATUS, {21'h0, 3'(cyc), 1'b0, p2_m, p1_m, sk, pwrdn_m, to_m, 1'b0,
            op == MBI_HALT_OP}, 32'h77d);
    endtask

    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (notes.size() == 0) begin
                err_count++;
                $display("unexpected read %h exp none got %h", paddr, prdata);
            end else begin
                cur = notes.pop_front();
                if (cur.m != 0) check_read(cur, prdata, pslverr);
            end
        end
        if (wdt_clear === 1'b1) wclr_n++;
        prog_data <= rom(prog_addr);
        cyc_n++;
        if (cyc_n == 20000) begin
            err_count++;
            results();
        end
    end

    initial begin
        mbi_op_type op;
        mbi_op_type t5[4];
        logic [7:0] v, r;
        logic [15:0] w;
        logic sk;
        t5 = '{MBI_INC_SKIP_ZERO_OP, MBI_DEC_SKIP_ZERO_OP, MBI_INC_SKIP_ZERO_ACC_OP,
               MBI_DEC_SKIP_ZERO_ACC_OP};
        seed = 32'hbf88;
        {psel, penable, pwrite, wdt_timeout, to_m, pwrdn_m, p1_m, p2_m} = '0;
        {paddr, pwdata, prog_data, err_count, total_checks, cyc_n, wclr_n} = '0;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_PC, 32'h0);
        rd(8'h20, 32'h0, '1, 1'b1);
        run(MBI_JUMP_OP, 0, 0, 32'h1abc, 2, 1'b0);
        rd(ADDR_PC, 32'h1abc);
        run(MBI_NOP_OP, 0, 0, 32'h0, 1, 1'b0);
        rd(ADDR_PC, 32'h1abd);
        $display("test jump done");
        for (int k = 0; k < 4; k++) begin
            op = k[1] ? MBI_SKIP_ZERO_COPY_OP : MBI_SKIP_ZERO_OP;
            v = k[0] ? (8'($random(seed)) | 8'h01) : 8'h00;
            wr(ma(5), v);
            wr(ADDR_PC, 32'h100);
            wr(ADDR_ACC, 32'h0);
            run(op, 5, 0, 32'h0, (v == 0) ? 2 : 1, v == 0);
            rd(ADDR_PC, (v == 0) ? 32'h102 : 32'h101);
            rd(ADDR_ACC, k[1] ? {24'h0, v} : 32'h0);
        end
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            wr(ma(3), v);
            for (int k = 0; k < 2; k++) begin
                op = k[0] ? MBI_SKIP_BIT_SET_OP : MBI_SKIP_BIT_CLEAR_OP;
                sk = k[0] ? v[i] : !v[i];
                wr(ADDR_PC, 32'h300);
                run(op, 3, i, 32'h0, sk ? 2 : 1, sk);
                rd(ADDR_PC, sk ? 32'h302 : 32'h301);
            end
        end
        $display("test skip done");
        for (int k = 0; k < 8; k++) begin
            v = k[0] ? 8'($random(seed)) : ((k / 2) % 2 == 0 ? 8'hff : 8'h01);
            r = ((k / 2) % 2 == 0) ? v + 8'h01 : v - 8'h01;
            wr(ma(7), v);
            wr(ADDR_ACC, 32'h0);
            wr(ADDR_PC, 32'h200);
            run(t5[k / 2], 7, 0, 32'h0, (r == 0) ? 2 : 1, r == 0);
            rd(ma(7), {24'h0, (k >= 4) ? v : r});
            rd(ADDR_ACC, (k >= 4) ? {24'h0, r} : 32'h0);
            rd(ADDR_PC, (r == 0) ? 32'h202 : 32'h201);
        end
        $display("test step done");
        wr(ADDR_STACK, 32'h0777);
        for (int k = 0; k < 3; k++) begin
            op = (k == 0) ? MBI_RETURN_OP : (k == 1) ? MBI_RETURN_IMM_OP : MBI_RETURN_FROM_IRQ_OP;
            wr(ADDR_ACC, 32'h0);
            run(op, 0, 0, 32'ha5, 2, 1'b0);
            rd(ADDR_PC, 32'h0777);
            rd(ADDR_ACC, (k == 1) ? 32'ha5 : 32'h0);
        end
        wr(ADDR_PC, 32'h0a12);
        run(MBI_TABLE_READ_CURRENT_PAGE, 4, 0, 32'h37, 2, 1'b0);
        w = rom(13'h0a37);
        rd(ma(4), {24'h0, w[7:0]});
        rd(ADDR_TABLE_HIGH, {24'h0, w[15:8]});
        run(MBI_TABLE_READ_LAST_PAGE, 4, 0, 32'h9e, 2, 1'b0);
        w = rom({LAST_PAGE, 8'h9e});
        rd(ma(4), {24'h0, w[7:0]});
        rd(ADDR_TABLE_HIGH, {24'h0, w[15:8]});
        $display("test return and table done");
        wr(ma(6), 32'(8'($random(seed))));
        run(MBI_SET_MEM_OP, 6, 0, 32'h0, 1, 1'b0);
        rd(ma(6), 32'hff);
        run(MBI_CLEAR_MEM_OP, 6, 0, 32'h0, 1, 1'b0);
        rd(ma(6), 32'h0);
        wr(ADDR_PC, 32'h340);
        run(MBI_SET_MEM_OP, int'(PC_LOW_INDEX), 0, 32'h0, 2, 1'b0);
        rd(ADDR_PC, 32'h3ff);
        v = 8'($random(seed));
        wr(ma(9), v);
        run(MBI_NIBBLE_EXCHANGE, 9, 0, 32'h0, 1, 1'b0);
        rd(ma(9), {24'h0, v[3:0], v[7:4]});
        run(MBI_NIBBLE_EXCHANGE_TO_ACC, 9, 0, 32'h0, 1, 1'b0);
        rd(ADDR_ACC, {24'h0, v});
        rd(ma(9), {24'h0, v[3:0], v[7:4]});
        $display("test memory done");
        @(posedge pclk);
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        to_m = 1'b1;
        wclr_n = 0;
        p1_m = 1'b1;
        run(MBI_WATCHDOG_PRECLEAR_ONE, 0, 0, 32'h0, 1, 1'b0);
        run(MBI_WATCHDOG_PRECLEAR_ONE, 0, 0, 32'h0, 1, 1'b0);
        check_port("wdt_clear count", 32'd0, wclr_n);
        {p1_m, to_m} = 2'b00;
        run(MBI_WATCHDOG_PRECLEAR_TWO, 0, 0, 32'h0, 1, 1'b0);
        check_port("wdt_clear count", 32'd1, wclr_n);
        pwrdn_m = 1'b1;
        run(MBI_HALT_OP, 0, 0, 32'h0, 1, 1'b0);
        check_port("powerdown", 32'd1, {31'h0, powerdown});
        check_port("wdt_clear count", 32'd2, wclr_n);
        wr(ADDR_INSTR, {27'h0, MBI_NOP_OP});
        rd(ADDR_STATUS, 32'h3, 32'h3);
        wr(ADDR_WAKE, 32'h1);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        check_port("powerdown", 32'd0, {31'h0, powerdown});
        pwrdn_m = 1'b0;
        run(MBI_WATCHDOG_CLEAR, 0, 0, 32'h0, 1, 1'b0);
        check_port("wdt_clear count", 32'd3, wclr_n);
        $display("test watchdog done");
        results();
    end
endmodule
